// >>> digipot_serial_command_slave.sv
/*
  digipot_serial_command_slave: two-wire serial slave front end of a
  one- or two-channel 256-position digital potentiometer.
  assumes: scl and sda arrive asynchronous and are far slower than clk_sys_in;
  the sda pad is open drain and resolved outside (oe low means drive low).
*/
`timescale 1ns/10ps

// What this block does
// [R1] read: data byte follows address acknowledge, no instruction byte
// [R2] read byte: eight data bits driven, master leaves ninth bit high
// [R3] data line changes only while clock low, stable during high
// [R4] rising data while clock high is a stop, ends transaction
// [R5] write: master raises data during tenth clock to form stop
// [R6] read: master nacks, pulls low, releases high under clock for stop
// [R7] each further written data byte updates selected wiper immediately
// [R8] new instruction needs a fresh address, instruction and data sequence
// [R9] repeated reads keep returning selected channel's wiper value
// [R10] read returns wiper of channel selected most recently in write
// [R11] channel select latched from instruction byte alone
// [R12] respond only when address bits match the two address pins
// [R13] logic outputs low after power-up
// [R14] logic outputs set from instruction bits on each accepted instruction
// [R15] instruction-only write updates outputs and leaves wiper unchanged unless midscale bit set
// [R16] new start accepted after completed write or in place of stop
// [R17] shutdown from active-low pin or soft shutdown bit
// [R18] soft shutdown keeps wiper setting, restored on next command
// [R19] output wired to shutdown pin: programmable while shut, high exits
// [R20] address is fixed five-bit prefix, pin bits, then direction bit
// [R21] acknowledge address and each write byte by pulling data low
// [R22] instruction: channel, midscale, shutdown, output two, output one
// [R23] midscale bit moves selected wiper to centre code
// [R24] eight-bit wipers preset to 128, bytes shifted msb first
// [R25] start while addressed is a repeated start, expect new address
module digipot_serial_command_slave
  import digipot_pkg::*;
#(
  parameter int channels = 2
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // serial link pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n_out,
  // address and shutdown pins
  input wire logic address_pin_zero_in,
  input wire logic address_pin_one_in,
  input wire logic shutdown_input_n_in,
  // potentiometer side
  output logic [7:0] first_channel_wiper_out,
  output logic [7:0] second_channel_wiper_out,
  output digipot_pkg::ctrl_out_s ctrl_out
);
  import digipot_pkg::*;

  // refuse channel counts the wiper store cannot serve
  if (channels < 1 || channels > 2)
  begin : bad_channels
    $error("channels must be 1 or 2");
  end

  typedef struct packed {
    line_s sync1;
    line_s sync2;
    line_s prev;
    logic [1:0] pins1;
    logic [1:0] pins2;
    logic shdn1;
    logic shdn2;
    phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic in_ack;
    logic drive_low;
    logic chan;
    logic soft_sd;
    logic out_one;
    logic out_two;
    logic [1:0][7:0] wiper;
  } state_s;

  state_s r;
  state_s next_r;

  function automatic logic addr_match(input logic [6:0] a, input logic [1:0] pins);
    addr_match = (a[6:2] == addr_prefix) && (a[1:0] == pins); // [R12] [R20]
  endfunction

  // channel named by an instruction byte; a one-channel part always uses 0
  function automatic logic chan_of(input logic [7:0] instr);
    chan_of = (channels > 1) ? instr[instr_chan_pos] : 1'b0; // [R10] [R22]
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] got;

  always_comb
  begin
    // edge detection on synchronised lines only
    scl_rise = r.sync2.scl & ~r.prev.scl;
    scl_fall = ~r.sync2.scl & r.prev.scl;
    start_cond = r.sync2.scl & r.prev.scl & r.prev.sda & ~r.sync2.sda;
    stop_cond = r.sync2.scl & r.prev.scl & ~r.prev.sda & r.sync2.sda; // [R4]
    got = {r.shreg[6:0], r.sync2.sda};
    next_r = r;
    next_r.sync1 = '{scl: scl_in, sda: sda_in};
    next_r.sync2 = r.sync1;
    next_r.prev = r.sync2;
    next_r.pins1 = {address_pin_one_in, address_pin_zero_in};
    next_r.pins2 = r.pins1;
    next_r.shdn1 = shutdown_input_n_in;
    next_r.shdn2 = r.shdn1;
    if (start_cond)
    begin
      // [R16] [R25]
      next_r.phase = st_addr;
      next_r.bit_cnt = bit_cnt_zero;
      next_r.in_ack = 1'b0;
      next_r.drive_low = 1'b0;
    end
    else if (stop_cond)
    begin
      next_r.phase = st_idle;
      next_r.in_ack = 1'b0;
      next_r.drive_low = 1'b0;
    end
    else if (r.phase != st_idle)
    begin
      if (scl_rise && !r.in_ack)
      begin
        next_r.shreg = got; // [R24] [R3]
        next_r.bit_cnt = r.bit_cnt + 4'h1;
      end
      if (scl_rise && r.in_ack && r.phase == st_read && r.sync2.sda)
      begin
        // master nack: release bus and wait for stop
        next_r.phase = st_idle; // [R2] [R6]
      end
      if (scl_fall)
      begin
        if (r.in_ack)
        begin
          // ninth clock done, set up next byte
          next_r.in_ack = 1'b0;
          next_r.bit_cnt = bit_cnt_zero;
          next_r.drive_low = 1'b0;
          if (r.phase == st_read)
          begin
            next_r.tx = r.wiper[r.chan]; // [R9] [R10]
            next_r.drive_low = ~r.wiper[r.chan][byte_bits - 1];
          end
        end
        else if (r.bit_cnt == bit_cnt_ack)
        begin
          next_r.in_ack = 1'b1;
          next_r.drive_low = 1'b0;
          case (r.phase)
            st_addr:
            begin
              if (addr_match(r.shreg[7:1], r.pins2))
              begin
                next_r.drive_low = 1'b1; // [R21]
                if (r.shreg[0])
                begin
                  next_r.phase = st_read; // [R1]
                  next_r.soft_sd = 1'b0; // [R18]
                end
                else
                begin
                  next_r.phase = st_instr;
                end
              end
              else
              begin
                next_r.phase = st_idle;
                next_r.in_ack = 1'b0;
              end
            end
            st_instr:
            begin
              next_r.drive_low = 1'b1; // [R21]
              next_r.phase = st_data; // [R8]
              next_r.chan = chan_of(r.shreg); // [R11] [R22]
              next_r.soft_sd = r.shreg[instr_soft_sd_pos]; // [R17] [R18]
              next_r.out_two = r.shreg[instr_out_two_pos]; // [R14] [R15]
              next_r.out_one = r.shreg[instr_out_one_pos]; // [R14] [R19]
              if (r.shreg[instr_midscale_pos])
              begin
                next_r.wiper[chan_of(r.shreg)] = wiper_midscale; // [R23]
              end
            end
            st_data:
            begin
              next_r.drive_low = 1'b1; // [R21]
              next_r.wiper[r.chan] = r.shreg; // [R7]
            end
            default:
            begin
              // read byte done, release for master ack bit
              next_r.drive_low = 1'b0; // [R2]
            end
          endcase
        end
        else if (r.phase == st_read)
        begin
          // shift next read bit out while clock is low
          next_r.tx = {r.tx[6:0], 1'b0}; // [R3]
          next_r.drive_low = ~r.tx[byte_bits - 2];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r <= '0;
      r.sync1 <= '{scl: 1'b1, sda: 1'b1};
      r.sync2 <= '{scl: 1'b1, sda: 1'b1};
      r.prev <= '{scl: 1'b1, sda: 1'b1};
      r.shdn1 <= 1'b1;
      r.shdn2 <= 1'b1;
      r.phase <= st_idle;
      r.wiper <= {wiper_midscale, wiper_midscale}; // [R24]
      r.out_one <= 1'b0; // [R13]
      r.out_two <= 1'b0; // [R13]
    end
    else
    begin
      r <= next_r;
    end
  end

  assign sda_oe_n_out = ~r.drive_low;
  assign first_channel_wiper_out = r.wiper[0];
  assign second_channel_wiper_out = r.wiper[1];
  assign ctrl_out.logic_output_one = r.out_one;
  assign ctrl_out.logic_output_two = r.out_two;
  assign ctrl_out.shutdown_active = r.soft_sd | ~r.shdn2; // [R17] [R19]

endmodule

// >>> digipot_pkg.sv
/*
  digipot_pkg: constants and carrier types for the two-wire digipot slave.
  assumes: included before the slave module; no clocking of its own.
*/
package digipot_pkg;

  localparam logic [4:0] addr_prefix = 5'h0b;
  localparam logic [7:0] wiper_midscale = 8'h80;
  localparam int byte_bits = 8;
  localparam int bit_cnt_w = 4;
  localparam logic [3:0] bit_cnt_ack = 4'h8;
  localparam logic [3:0] bit_cnt_zero = 4'h0;

  // instruction byte field positions
  localparam int instr_chan_pos = 7;
  localparam int instr_midscale_pos = 6;
  localparam int instr_soft_sd_pos = 5;
  localparam int instr_out_two_pos = 4;
  localparam int instr_out_one_pos = 3;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_instr,
    st_data,
    st_read
  } phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

  typedef struct packed {
    logic logic_output_one;
    logic logic_output_two;
    logic shutdown_active;
  } ctrl_out_s;

endpackage

// >>> digipot_serial_command_slave_asserts.sv
/* port checker for the digipot slave
   assumes: bound into the slave, one clock */
`timescale 1ns/10ps
module digipot_port_chk
  import digipot_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic shutdown_input_n_in,
  input wire logic [7:0] first_channel_wiper_out,
  input wire logic [7:0] second_channel_wiper_out,
  input wire digipot_pkg::ctrl_out_s ctrl_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  pull_low_a: assert property ($fell(sda_oe_n_out) |-> !scl_in) else $error("pull in high");
  let_go_a: assert property ($rose(sda_oe_n_out) |-> !scl_in) else $error("release in high");
  ack_hold_a: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*4]) else $error("short pull");
  out_reset_a: assert property ($rose(nrst_in) |-> ctrl_out[2:1] == 2'b00) else $error("outputs set");
  wiper_reset_a: assert property ($rose(nrst_in) |-> first_channel_wiper_out == wiper_midscale)
    else $error("bad preset");
  pin_shut_a: assert property (!shutdown_input_n_in [*4] |-> ctrl_out.shutdown_active) else $error("pin lost");
  wiper_edge_a: assert property ($changed({first_channel_wiper_out, second_channel_wiper_out}) |-> !scl_in)
    else $error("wiper in high");
  out_edge_a: assert property ($changed(ctrl_out[2:1]) |-> !scl_in) else $error("outputs in high");
endmodule
bind digipot_serial_command_slave digipot_port_chk chk (.clk_sys_in, .nrst_in, .scl_in, .sda_oe_n_out,
  .shutdown_input_n_in, .first_channel_wiper_out, .second_channel_wiper_out, .ctrl_out);

// >>> digipot_bus_master.sv
/* two-wire bus master model
   assumes: data line pulled up in the bench */
`timescale 1ns/10ps
module digipot_bus_master
(
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial scl_out = 1'b1;
  initial sda_low_out = 1'b0;
  task automatic clock_bit(input logic b, output logic q);
    #80 sda_low_out = !b;
    #80 scl_out = 1'b1;
    #160 q = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic frame(input logic first, input logic last);
    #80 sda_low_out = first;
    #80 scl_out = 1'b1;
    #160 sda_low_out = last;
    if (last) #160 scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, input logic nine, output logic [7:0] d, output logic q);
    for (int i = 7; i >= 0; i--) clock_bit(b[i], d[i]);
    clock_bit(nine, q);
  endtask
endmodule

// >>> tb_digipot_serial_command_slave.sv
/* bench for the digipot slave and a bus master model
   assumes: package, slave, checker, master compiled first */
`timescale 1ns/10ps
module tb_digipot_serial_command_slave;
  import digipot_pkg::*;
  localparam logic [7:0] aw = {addr_prefix, 2'b10, 1'b0};
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, pin_n = 1'b1;
  logic scl, drv_low, oe_n, q;
  logic [7:0] w1, w2, d;
  ctrl_out_s co;
  int mismatches = 0, compares = 0, cycles = 0;
  wire sda = !(drv_low || !oe_n);
  wire [7:0] st = {5'h00, co.shutdown_active, co.logic_output_two, co.logic_output_one};
  digipot_bus_master m (.sda_in(sda), .scl_out(scl), .sda_low_out(drv_low));
  digipot_serial_command_slave uut (.clk_sys_in, .nrst_in, .scl_in(scl), .sda_in(sda), .sda_oe_n_out(oe_n),
    .address_pin_zero_in(1'b0), .address_pin_one_in(1'b1), .shutdown_input_n_in(pin_n),
    .first_channel_wiper_out(w1), .second_channel_wiper_out(w2), .ctrl_out(co));
  always #20 clk_sys_in = !clk_sys_in;
  always @(posedge clk_sys_in) if (++cycles == 20000) test_done(1);
  task automatic test_done(input int extra);
    mismatches += extra;
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    mismatches += int'(seen !== exp);
    if (seen !== exp) $display("unexpected %0t: %h not %h", $time, seen, exp);
  endtask
  task automatic wb(input logic [7:0] b, input logic ack);
    m.xfer(b, 1'b1, d, q);
    chk({7'h00, !q}, {7'h00, ack});
  endtask
  task automatic rb(input logic nack, input logic [7:0] exp);
    m.xfer(8'hff, nack, d, q);
    chk(d, exp);
  endtask
  task automatic go(input logic [7:0] a);
    m.frame(1'b0, 1'b1);
    wb(a, 1'b1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    #2 nrst_in = 1'b1;
    m.frame(1'b0, 1'b1);
    wb(aw ^ 8'h04, 1'b0);
    go(aw);
    wb(8'h00, 1'b1);
    wb(8'h11, 1'b1);
    go(aw);
    wb(8'h88, 1'b1);
    m.frame(1'b1, 1'b0);
    chk(w1, 8'h11);
    chk(w2, 8'h80);
    chk(st, 8'h01);
    go(aw);
    wb(8'h90, 1'b1);
    wb(8'h5a, 1'b1);
    chk(w2, 8'h5a);
    wb(8'hc3, 1'b1);
    go(aw | 8'h01);
    rb(1'b0, 8'hc3);
    rb(1'b1, 8'hc3);
    m.frame(1'b1, 1'b0);
    go(aw);
    wb(8'h67, 1'b1);
    chk(w1, 8'h80);
    chk(st, 8'h04);
    go(aw | 8'h01);
    rb(1'b1, 8'h80);
    m.frame(1'b1, 1'b0);
    chk(st, 8'h00);
    chk(w2, 8'hc3);
    @(posedge clk_sys_in);
    #2 pin_n = 1'b0;
    go(aw);
    wb(8'h08, 1'b1);
    m.frame(1'b1, 1'b0);
    chk(st, 8'h05);
    test_done(0);
  end
endmodule
